/* File: core/ers_pkg.sv */
// Package for the elevator run sequencer: register map, timing, states
package ers_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_STATE = 8'h00;
    localparam logic [7:0] OFF_CREEP = 8'h04;
    localparam logic [7:0] OFF_FLOOR = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0C;
    localparam logic [7:0] OFF_BRREL = 8'h10;
    localparam logic [7:0] OFF_LOAD = 8'h14;
    localparam logic [7:0] OFF_BRAPP = 8'h18;
    localparam logic [7:0] OFF_DEMAG = 8'h1C;
    localparam logic [7:0] OFF_ROPE = 8'h20;
    localparam logic [7:0] OFF_SPEED = 8'h24;
    // Control register fields
    localparam int CTRL_DIRREQ = 0;
    localparam int CTRL_SERVO = 1;
    // Reset values
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_ROPE = 16'h0001;
    localparam logic [15:0] RST_LOAD = 16'h00C8;
    // Start request threshold on the speed selection value
    localparam logic [15:0] START_THRESH = 16'h0712;
    // Default creep speed parameter number (menu 18, parameter 11)
    localparam logic [15:0] CREEP_DEFAULT = 16'h0713;
    // Update tick: 4 ms at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int TICK_MS = 4;
    localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
    // Fixed waits in ms and in whole ticks, rounded up
    localparam int DEBOUNCE_MS = 100;
    localparam int SERVO_MAG_MS = 100;
    localparam int IND_DECAY_MS = 200;
    localparam logic [15:0] DEBOUNCE_TK = 16'((DEBOUNCE_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [15:0] SERVO_MAG_TK = 16'((SERVO_MAG_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [15:0] IND_DECAY_TK = 16'((IND_DECAY_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [15:0] TICK_MS16 = 16'(TICK_MS);
    // Floor approach source codes
    localparam logic [2:0] FA_CREEP = 3'h0;
    localparam logic [2:0] FA_AIN3 = 3'h3;
    localparam logic [2:0] FA_SPDOFF = 3'h4;
    localparam logic [2:0] FA_DIST = 3'h5;
    typedef enum logic [2:0] {
        ST_IDLE, ST_DEBOUNCE, ST_MAGNET, ST_BRAKE_REL,
        ST_RUN, ST_BRAKE_APP, ST_DECAY, ST_RELEASE
    } ers_state_type;
endpackage : ers_pkg

/* File: core/ers_sequencer.sv */
// Elevator run sequencer with APB register slave
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module ers_sequencer
    import ers_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Lift controller and drive status
    input wire logic [15:0] speedSelectionValue,
    input wire logic directionSignal,
    input wire logic startSignal,
    input wire logic rampActive,
    input wire logic contactorFeedbackInput,
    input wire logic motorMagnetised,
    input wire logic analogInputOne,
    input wire logic analogInputTwo,
    input wire logic analogInputThree,
    // Sequencer outputs
    output logic contactorOn,
    output logic currentEnable,
    output logic brakeRelease,
    output logic rampEnable,
    output logic loadMeasureActive,
    output logic [15:0] creepSpeedParam,
    output logic directFloorEnable,
    output logic floorStopRequest,
    output logic distanceControl,
    output logic [15:0] nominalSpeed
);
    logic [31:0] tickCnt_q, tickCnt_d;
    logic tick_q, tick_d;
    ers_state_type state_q, state_d;
    logic [15:0] timer_q, timer_d;
    logic [15:0] loadTimer_q, loadTimer_d;
    logic [15:0] creepSel_q, creepSel_d;
    logic [15:0] floorSel_q, floorSel_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] brRel_q, brRel_d;
    logic [15:0] loadTime_q, loadTime_d;
    logic [15:0] brApp_q, brApp_d;
    logic [15:0] demag_q, demag_d;
    logic [15:0] rope_q, rope_d;
    logic [15:0] autoSpeed_q, autoSpeed_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic contactor_d, current_d, brake_d, ramp_d, loadAct_d;
    logic [15:0] creepOut_d, nominal_d;
    logic dtf_d, floorStop_d, dist_d;
    logic access, wr, mapped;
    logic startReq, servo;
    logic [15:0] timerInc, ticksBrRel, ticksLoad, ticksBrApp, ticksDemag;
    logic [31:0] ropeProd;

    // One-cycle tick enable from a divider
    always_comb begin
        tickCnt_d = tickCnt_q + 32'h0000_0001;
        tick_d = 1'b0;
        if (tickCnt_q >= 32'(TICK_CYCLES - 1)) begin
            tickCnt_d = 32'h0000_0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tickCnt_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            tickCnt_q <= tickCnt_d;
            tick_q <= tick_d;
        end
    end

    // APB register file; answers in the access cycle, no wait states
    assign access = psel && penable;
    assign wr = access && pwrite;
    always_comb begin
        mapped = 1'b1;
        case (paddr)
            OFF_STATE, OFF_CREEP, OFF_FLOOR, OFF_CTRL, OFF_BRREL,
            OFF_LOAD, OFF_BRAPP, OFF_DEMAG, OFF_ROPE, OFF_SPEED: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        creepSel_d = creepSel_q;
        floorSel_d = floorSel_q;
        ctrl_d = ctrl_q;
        brRel_d = brRel_q;
        loadTime_d = loadTime_q;
        brApp_d = brApp_q;
        demag_d = demag_q;
        rope_d = rope_q;
        prdata_d = 32'h0000_0000;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (psel && !penable) begin
            pready_d = 1'b1;
            pslverr_d = !mapped;
        end
        // Read data is latched in setup so that it stands beside pready
        if (psel && !penable && !pwrite) begin
            case (paddr)
                OFF_STATE: prdata_d = {16'h0000, 13'h0000, state_q};
                OFF_CREEP: prdata_d = {16'h0000, creepSel_q};
                OFF_FLOOR: prdata_d = {16'h0000, floorSel_q};
                OFF_CTRL: prdata_d = {16'h0000, ctrl_q};
                OFF_BRREL: prdata_d = {16'h0000, brRel_q};
                OFF_LOAD: prdata_d = {16'h0000, loadTime_q};
                OFF_BRAPP: prdata_d = {16'h0000, brApp_q};
                OFF_DEMAG: prdata_d = {16'h0000, demag_q};
                OFF_ROPE: prdata_d = {16'h0000, rope_q};
                OFF_SPEED: prdata_d = {16'h0000, autoSpeed_q};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (paddr)
                OFF_CREEP: creepSel_d = pwdata[15:0];
                OFF_FLOOR: floorSel_d = pwdata[15:0];
                OFF_CTRL: ctrl_d = {14'h0000, pwdata[1:0]};
                OFF_BRREL: brRel_d = pwdata[15:0];
                OFF_LOAD: loadTime_d = pwdata[15:0];
                OFF_BRAPP: brApp_d = pwdata[15:0];
                OFF_DEMAG: demag_d = pwdata[15:0];
                OFF_ROPE: rope_d = pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Data phase outputs are registered, so pready rises in the access cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            creepSel_q <= RST_ZERO;
            floorSel_q <= RST_ZERO;
            ctrl_q <= RST_ZERO;
            brRel_q <= RST_ZERO;
            loadTime_q <= RST_LOAD;
            brApp_q <= RST_ZERO;
            demag_q <= RST_ZERO;
            rope_q <= RST_ROPE;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            creepSel_q <= creepSel_d;
            floorSel_q <= floorSel_d;
            ctrl_q <= ctrl_d;
            brRel_q <= brRel_d;
            loadTime_q <= loadTime_d;
            brApp_q <= brApp_d;
            demag_q <= demag_d;
            rope_q <= rope_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    // Programmable times are in ms; converted to ticks, rounded up
    function automatic logic [15:0] ms_to_ticks(input logic [15:0] ms);
        logic [16:0] sum;
        sum = {1'b0, ms} + {1'b0, TICK_MS16} - 17'h0_0001;
        return 16'(sum / {1'b0, TICK_MS16});
    endfunction : ms_to_ticks

    assign ticksBrRel = ms_to_ticks(brRel_q);
    assign ticksLoad = ms_to_ticks(loadTime_q);
    assign ticksBrApp = ms_to_ticks(brApp_q);
    assign ticksDemag = ms_to_ticks(demag_q);
    assign servo = ctrl_q[CTRL_SERVO];
    assign timerInc = (timer_q == 16'hFFFF) ? timer_q : timer_q + 16'h0001;
    assign startReq = (speedSelectionValue > START_THRESH)
        && (!ctrl_q[CTRL_DIRREQ] || directionSignal);

    // Run sequencer, advanced only on the update tick
    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        loadTimer_d = loadTimer_q;
        contactor_d = contactorOn;
        current_d = currentEnable;
        brake_d = brakeRelease;
        ramp_d = rampEnable;
        loadAct_d = 1'b0;
        if (tick_q) begin
            timer_d = timerInc;
            case (state_q)
                ST_IDLE: begin
                    timer_d = 16'h0000;
                    contactor_d = startReq;
                    if (startReq && contactorFeedbackInput) begin
                        state_d = ST_DEBOUNCE;
                    end
                end
                ST_DEBOUNCE: begin
                    if (timerInc >= DEBOUNCE_TK) begin
                        current_d = 1'b1;
                        timer_d = 16'h0000;
                        state_d = ST_MAGNET;
                    end
                end
                ST_MAGNET: begin
                    if (servo ? (timerInc >= SERVO_MAG_TK) : motorMagnetised) begin
                        brake_d = 1'b1;
                        timer_d = 16'h0000;
                        loadTimer_d = 16'h0000;
                        state_d = ST_BRAKE_REL;
                    end
                end
                ST_BRAKE_REL: begin
                    // Load measurement starts once the brake release time is over
                    if (timerInc > ticksBrRel && loadTimer_q < ticksLoad) begin
                        loadTimer_d = loadTimer_q + 16'h0001;
                        loadAct_d = 1'b1;
                    end
                    if (timerInc >= ticksBrRel && loadTimer_d >= ticksLoad) begin
                        ramp_d = 1'b1;
                        state_d = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!startSignal && speedSelectionValue == 16'h0000 && !rampActive) begin
                        brake_d = 1'b0;
                        ramp_d = 1'b0;
                        timer_d = 16'h0000;
                        state_d = ST_BRAKE_APP;
                    end
                end
                ST_BRAKE_APP: begin
                    if (timerInc >= ticksBrApp) begin
                        current_d = 1'b0;
                        timer_d = 16'h0000;
                        state_d = ST_DECAY;
                    end
                end
                ST_DECAY: begin
                    if (timerInc >= (servo ? ticksDemag : IND_DECAY_TK)) begin
                        contactor_d = 1'b0;
                        state_d = ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    if (!contactorFeedbackInput && !startReq) begin
                        state_d = ST_IDLE;
                    end
                end
                default: state_d = ST_IDLE;
            endcase
        end else begin
            loadAct_d = loadActiveHold();
        end
    end

    function automatic logic loadActiveHold();
        return loadMeasureActive;
    endfunction : loadActiveHold

    // Floor approach source and creep redirection
    assign ropeProd = 32'(speedSelectionValue) * 32'(rope_q);
    always_comb begin
        creepOut_d = (creepSel_q == RST_ZERO) ? CREEP_DEFAULT : creepSel_q;
        nominal_d = ropeProd[15:0];
        autoSpeed_d = nominal_d;
        dtf_d = (floorSel_q != RST_ZERO);
        floorStop_d = 1'b0;
        dist_d = 1'b0;
        case (floorSel_q[2:0])
            FA_CREEP: floorStop_d = 1'b0;
            3'h1: floorStop_d = analogInputOne;
            3'h2: floorStop_d = analogInputTwo;
            FA_AIN3: floorStop_d = analogInputThree;
            FA_SPDOFF: floorStop_d = (speedSelectionValue == 16'h0000);
            FA_DIST: dist_d = 1'b1;
            default: dtf_d = 1'b0;
        endcase
        if (floorSel_q > 16'(FA_DIST)) begin
            dtf_d = 1'b0;
            floorStop_d = 1'b0;
            dist_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            timer_q <= RST_ZERO;
            loadTimer_q <= RST_ZERO;
            autoSpeed_q <= RST_ZERO;
            contactorOn <= 1'b0;
            currentEnable <= 1'b0;
            brakeRelease <= 1'b0;
            rampEnable <= 1'b0;
            loadMeasureActive <= 1'b0;
            creepSpeedParam <= CREEP_DEFAULT;
            nominalSpeed <= RST_ZERO;
            directFloorEnable <= 1'b0;
            floorStopRequest <= 1'b0;
            distanceControl <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            loadTimer_q <= loadTimer_d;
            autoSpeed_q <= autoSpeed_d;
            contactorOn <= contactor_d;
            currentEnable <= current_d;
            brakeRelease <= brake_d;
            rampEnable <= ramp_d;
            loadMeasureActive <= loadAct_d;
            creepSpeedParam <= creepOut_d;
            nominalSpeed <= nominal_d;
            directFloorEnable <= dtf_d;
            floorStopRequest <= floorStop_d;
            distanceControl <= dist_d;
        end
    end
endmodule : ers_sequencer

/* File: tb/elevator_run_sequencer_bench.sv */
// Self-checking bench of the elevator run sequencer
`timescale 1ns/10ps
module elevator_run_sequencer_bench
    import ers_pkg::*;
;
    localparam int T = 10;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] speedSelectionValue, creepSpeedParam, nominalSpeed;
    logic directionSignal, startSignal, rampActive, contactorFeedbackInput, motorMagnetised;
    logic analogInputOne, analogInputTwo, analogInputThree, loadMeasureActive;
    logic contactorOn, currentEnable, brakeRelease, rampEnable;
    logic directFloorEnable, floorStopRequest, distanceControl;
    logic [3:0] outs;
    int n_fail, n_tests;
    int cycles = 0;
    assign outs = {contactorOn, currentEnable, brakeRelease, rampEnable};
    ers_sequencer #(.TICK_CYCLES(T)) dut_u (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .speedSelectionValue(speedSelectionValue),
        .directionSignal(directionSignal), .startSignal(startSignal), .rampActive(rampActive),
        .contactorFeedbackInput(contactorFeedbackInput), .motorMagnetised(motorMagnetised),
        .analogInputOne(analogInputOne), .analogInputTwo(analogInputTwo),
        .analogInputThree(analogInputThree), .contactorOn(contactorOn),
        .currentEnable(currentEnable), .brakeRelease(brakeRelease), .rampEnable(rampEnable),
        .loadMeasureActive(loadMeasureActive), .creepSpeedParam(creepSpeedParam),
        .directFloorEnable(directFloorEnable), .floorStopRequest(floorStopRequest),
        .distanceControl(distanceControl), .nominalSpeed(nominalSpeed));
    ers_lift_model #(.LAG(3)) lift_u (.clk(clk), .nrst(nrst), .contactorOn(contactorOn),
        .currentEnable(currentEnable), .contactorFeedbackInput(contactorFeedbackInput),
        .motorMagnetised(motorMagnetised));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    task print_verdict;
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Holds the request until pready is sampled high at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rdChk
    task waitTk(input int n);
        repeat (n * T) @(posedge clk);
    endtask : waitTk
    task waitOut(input int sel, input logic lvl, output int c);
        c = 0;
        while (outs[sel] !== lvl && c < 2000) begin
            @(negedge clk);
            c++;
        end
    endtask : waitOut
    task regTests;
        rdChk(OFF_STATE, 0);
        rdChk(OFF_CREEP, 0);
        rdChk(OFF_FLOOR, 0);
        rdChk(OFF_ROPE, RST_ROPE);
        rdChk(OFF_LOAD, RST_LOAD);
        check(creepSpeedParam, CREEP_DEFAULT);
        apb(1'b1, OFF_STATE, 32'h0000_0005);
        rdChk(OFF_STATE, 0);
        rdChk(8'h30, 0);
        check(err, 1'b1);
        apb(1'b1, OFF_CREEP, 32'h0000_0715);
        waitTk(2);
        check(creepSpeedParam, 16'h0715);
        apb(1'b1, OFF_CREEP, 32'h0000_0000);
        apb(1'b1, OFF_ROPE, 32'h0000_0002);
        speedSelectionValue <= 16'h0300;
        waitTk(2);
        check(creepSpeedParam, CREEP_DEFAULT);
        check(nominalSpeed, 16'h0600);
        speedSelectionValue <= 16'h0000;
    endtask : regTests
    // Direct-only modes are run at standstill, with the speed selection value at zero
    task floorModes;
        for (int m = 0; m < 7; m++) begin
            apb(1'b1, OFF_FLOOR, m);
            {analogInputThree, analogInputTwo, analogInputOne} <= 3'((8'h01 << m) >> 1);
            waitTk(2);
            check({directFloorEnable, floorStopRequest, distanceControl},
                {m > 0 && m < 6, m > 0 && m < 5, m == 5});
        end
        apb(1'b1, OFF_FLOOR, 32'h0000_0000);
    endtask : floorModes
    task startGate;
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        startSignal <= 1'b1;
        speedSelectionValue <= 16'h0800;
        waitTk(4);
        check(contactorOn, 1'b0);
        directionSignal <= 1'b1;
        speedSelectionValue <= START_THRESH;
        waitTk(4);
        check(contactorOn, 1'b0);
    endtask : startGate
    // Servo trip also runs a two-tick load measurement
    task trip(input logic servo);
        int c;
        apb(1'b1, OFF_CTRL, {30'h0000_0000, servo, 1'b1});
        apb(1'b1, OFF_BRREL, 32'h0000_0008);
        apb(1'b1, OFF_LOAD, {28'h000_0000, servo, 3'h0});
        apb(1'b1, OFF_BRAPP, 32'h0000_0004);
        apb(1'b1, OFF_DEMAG, 32'h0000_0008);
        startSignal <= 1'b1;
        rampActive <= 1'b1;
        speedSelectionValue <= 16'h0713;
        waitOut(3, 1'b1, c);
        check(c < 2 * T, 1'b1);
        waitOut(2, 1'b1, c);
        check(c >= 25 * T && c <= 27 * T, 1'b1);
        waitOut(1, 1'b1, c);
        check(c > 20 * T, servo);
        rdChk(OFF_STATE, 3);
        waitOut(0, 1'b1, c);
        check(c >= (servo ? 3 * T : T) && c <= 4 * T, 1'b1);
        check(loadMeasureActive, servo);
        rdChk(OFF_STATE, 4);
        rampActive <= 1'b0;
        startSignal <= 1'b0;
        speedSelectionValue <= 16'h0000;
        waitOut(1, 1'b0, c);
        check(rampEnable, 1'b0);
        waitOut(2, 1'b0, c);
        check(c <= 3 * T, 1'b1);
        waitOut(3, 1'b0, c);
        check(c >= (servo ? T : 49 * T) && c <= (servo ? 4 * T : 52 * T), 1'b1);
        waitTk(3);
        rdChk(OFF_STATE, 0);
    endtask : trip
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        {speedSelectionValue, directionSignal, startSignal, rampActive} = '0;
        {analogInputOne, analogInputTwo, analogInputThree} = '0;
        n_fail = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        regTests();
        floorModes();
        startGate();
        trip(1'b0);
        trip(1'b1);
        print_verdict();
    end
endmodule : elevator_run_sequencer_bench

/* File: tb/ers_lift_model.sv */
// Contactor and motor model on the lift side of the sequencer
`timescale 1ns/10ps
module ers_lift_model #(
    parameter int LAG = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Commands
    input wire logic contactorOn,
    input wire logic currentEnable,
    // Feedback
    output logic contactorFeedbackInput,
    output logic motorMagnetised
);
    logic [LAG-1:0] coil_q;
    logic [LAG-1:0] flux_q;
    // Contacts and flux follow late, so the block never sees instant feedback
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            coil_q <= '0;
            flux_q <= '0;
        end else begin
            coil_q <= {coil_q[LAG-2:0], contactorOn};
            flux_q <= {flux_q[LAG-2:0], currentEnable};
        end
    end
    assign contactorFeedbackInput = coil_q[LAG-1];
    assign motorMagnetised = flux_q[LAG-1];
endmodule : ers_lift_model

/* File: tb/ers_seq_monitor.sv */
// Port checker for the elevator run sequencer
`timescale 1ns/10ps
module ers_seq_monitor
    import ers_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Lift side
    input wire logic [15:0] speedSelectionValue,
    input wire logic startSignal,
    input wire logic rampActive,
    input wire logic contactorFeedbackInput,
    input wire logic contactorOn,
    input wire logic currentEnable,
    input wire logic brakeRelease,
    input wire logic rampEnable,
    input wire logic [15:0] creepSpeedParam,
    input wire logic directFloorEnable,
    input wire logic floorStopRequest,
    input wire logic distanceControl
);
    logic stopCond;
    assign stopCond = !startSignal && !rampActive && (speedSelectionValue == 16'h0000);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_apb_zero_wait: assert property (psel && penable |-> pready ##1 !pready)
        else $error("bus answer late or long");
    chk_start_above: assert property ($rose(contactorOn) |->
        $past(speedSelectionValue) > START_THRESH) else $error("start below threshold");
    chk_current_fb: assert property ($rose(currentEnable) |->
        contactorOn && contactorFeedbackInput) else $error("current without contactor");
    chk_mag_wait: assert property ($rose(currentEnable) |-> !brakeRelease[*2])
        else $error("brake with current");
    chk_brake_cur: assert property (brakeRelease |-> currentEnable)
        else $error("brake without current");
    chk_ramp_brake: assert property (rampEnable |-> brakeRelease)
        else $error("ramp without brake release");
    chk_stop_apply: assert property ($fell(brakeRelease) |-> $past(stopCond))
        else $error("brake applied while running");
    chk_decay_order: assert property ($fell(contactorOn) |->
        !currentEnable && !brakeRelease) else $error("contactor opened under current");
    chk_creep_set: assert property (creepSpeedParam != 16'h0000)
        else $error("creep parameter empty");
    chk_floor_mode: assert property (floorStopRequest || distanceControl |->
        directFloorEnable) else $error("floor stop outside direct mode");
    cover property ($rose(rampEnable));
    cover property ($fell(contactorOn));
    cover property (floorStopRequest && directFloorEnable);
endmodule : ers_seq_monitor
bind ers_sequencer ers_seq_monitor mon_u (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pready(pready), .speedSelectionValue(speedSelectionValue),
    .startSignal(startSignal), .rampActive(rampActive),
    .contactorFeedbackInput(contactorFeedbackInput), .contactorOn(contactorOn),
    .currentEnable(currentEnable), .brakeRelease(brakeRelease), .rampEnable(rampEnable),
    .creepSpeedParam(creepSpeedParam), .directFloorEnable(directFloorEnable),
    .floorStopRequest(floorStopRequest), .distanceControl(distanceControl));
